// [include/sfph_consts.svh]
// Constants of the flash write-protection and pause block.
// Assumes inclusion by bare name from the include folder.
`ifndef SFPH_CONSTS_SVH
`define SFPH_CONSTS_SVH

// Command opcodes
`define SFPH_OP_WRITE_ENABLE_CMD_C 8'h06
`define SFPH_OP_WRITE_DISABLE_CMD_C 8'h04
`define SFPH_OP_STATUS_WRITE_CMD_C 8'h01
`define SFPH_OP_PP_C 8'h02
`define SFPH_OP_SE_C 8'h20
`define SFPH_OP_BE_A_C 8'h52
`define SFPH_OP_BE_B_C 8'hd8
`define SFPH_OP_CE_A_C 8'h60
`define SFPH_OP_CE_B_C 8'hc7
`define SFPH_OP_DP_C 8'hb9
`define SFPH_OP_WAKE_C 8'hab
`define SFPH_OP_OTP_ENTER_CMD_C 8'hb1
`define SFPH_OP_OTP_EXIT_CMD_C 8'hc1
`define SFPH_OP_LOCK_WRITE_CMD_C 8'h2f
`define SFPH_OP_RDSCUR_C 8'h2b

// Whole bytes each command must carry
`define SFPH_LEN_SHORT_C 3'h1
`define SFPH_LEN_STATUS_WRITE_CMD_C 3'h2
`define SFPH_LEN_ERASE_C 3'h4
`define SFPH_LEN_PP_MIN_C 3'h5

// Status byte of the status write: field positions
`define SFPH_SR_LOCK_BIT_C 7
`define SFPH_SR_BP_LSB_C 2

// Security register bit positions
`define SFPH_SEC_FACT_BIT_C 0
`define SFPH_SEC_CUST_BIT_C 1

// One-time area: 64 bytes, first 16 hold the serial number
`define SFPH_OTP_AW_C 6
`define SFPH_OTP_DEPTH_C 64
`define SFPH_OTP_ESN_END_C 6'h0f

// Array geometry: block index is address bits 22..16
`define SFPH_BLK_MSB_C 22
`define SFPH_BLK_LSB_C 16
`define SFPH_BLK_COUNT_C 8'h80

// Reset values
`define SFPH_BP_RST_C 4'h0
// Pin synchroniser idle levels {wp, hold, si, sclk, cs}: serial clock idles low
`define SFPH_SYNC_RST_C 5'h1d

`endif

// [include/sfph_pkg.sv]
// Types of the flash write-protection and pause block.
// Assumes nothing of its surroundings.
package sfph_pkg;

  typedef enum logic [1:0] {ST_STANDBY, ST_SHIFT, ST_WAIT_DESEL} sfph_state_t;

  typedef enum logic [2:0] {OPK_NONE, OPK_STATUS_WRITE_CMD, OPK_PP, OPK_SE, OPK_BE, OPK_CE} sfph_opk_t;

endpackage

// [include/sfph_if.sv]
// Carriers between the top module and its pause unit and one-time memory.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns

interface sfph_hold_if;
  logic cs_n;
  logic sclk_lo;
  logic hold_n;
  logic paused;
  modport ctl (output cs_n, output sclk_lo, output hold_n, input paused);
  modport unit (input cs_n, input sclk_lo, input hold_n, output paused);
endinterface

interface sfph_mem_if;
  logic we;
  logic [5:0] waddr;
  logic [7:0] wdata;
  logic [5:0] raddr;
  logic [7:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// [rtl/sfph_otp_mem.sv]
// One-time area storage: 64 bytes, one write port, registered read port.
// Assumes the controller alone decides which bytes may still be written.
`timescale 1ns/1ns
`include "sfph_consts.svh"

module sfph_otp_mem
  import sfph_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Ports
  sfph_mem_if.mem m
);

  logic [7:0] mem_ff [0:`SFPH_OTP_DEPTH_C-1];
  logic [7:0] rdata_ff;

  always_ff @(posedge sys_clk_i) begin
    if (m.we) begin
      mem_ff[m.waddr] <= m.wdata;
    end
    rdata_ff <= mem_ff[m.raddr];
  end

  assign m.rdata = rdata_ff;

endmodule // sfph_otp_mem

// [rtl/sfph_hold.sv]
// Pause unit: enters the paused state on the serial clock low phase, leaves it on that phase or on deselect.
// Assumes synchronised pin levels from the top module.
`timescale 1ns/1ns

module sfph_hold
  import sfph_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Pin levels
  sfph_hold_if.unit h
);

  logic paused_ff;
  wire enter_ok = !h.cs_n && !h.hold_n && h.sclk_lo;
  wire leave_ok = h.hold_n && h.sclk_lo;
  wire nxt_paused = h.cs_n ? 1'b0 : (paused_ff ? !leave_ok : enter_ok);

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      paused_ff <= 1'b0;
    end else begin
      paused_ff <= nxt_paused;
    end
  end

  assign h.paused = paused_ff;

  a_pause_enter: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !paused_ff && !h.cs_n && !h.hold_n && h.sclk_lo |=> paused_ff)
    else $error("pause not entered with clock low");
  a_pause_waits_sclk: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    paused_ff && !h.cs_n && !h.sclk_lo |=> paused_ff)
    else $error("pause left while clock high");
  a_desel_ends_pause: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    h.cs_n |=> !paused_ff)
    else $error("pause survived deselect");

endmodule // sfph_hold

// [rtl/sfph_top.sv]
// Write-protection, one-time area and pause logic of a serial flash.
// Assumes an SPI mode 0 or 3 master on the pins and a core that runs operations.
`timescale 1ns/1ns
`include "sfph_consts.svh"

module sfph_top
  import sfph_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Serial pins
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic hold_n_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_o,
  // Factory strap
  input wire logic factory_lock_i,
  // Core operation port
  input wire logic busy_i,
  output logic op_start_o,
  output sfph_opk_t op_kind_o,
  output logic [23:0] op_addr_o,
  output logic [7:0] op_data_o,
  output logic cmd_reject_o,
  // Status
  output logic write_latch_o,
  output logic [3:0] protect_level_o,
  output logic status_write_lock_o,
  output logic deep_pd_o,
  output logic otp_mode_o,
  output logic [7:0] sec_reg_o,
  output logic paused_o,
  // One-time area read port
  input wire logic [5:0] otp_rd_addr_i,
  output logic [7:0] otp_rd_data_o
);

  // Pin synchronisers
  localparam int NSYNC = 5;
  localparam logic [NSYNC-1:0] SYNC_RST = `SFPH_SYNC_RST_C;
  wire [NSYNC-1:0] pins_raw = {wp_n_i, hold_n_i, si_i, sclk_i, cs_n_i};
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          sync1_ff[gi] <= SYNC_RST[gi];
          sync2_ff[gi] <= SYNC_RST[gi];
        end else begin
          sync1_ff[gi] <= pins_raw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
        end
      end
    end
  endgenerate
  wire cs_n_s = sync2_ff[0];
  wire sclk_s = sync2_ff[1];
  wire si_s = sync2_ff[2];
  wire hold_n_s = sync2_ff[3];
  wire wp_n_s = sync2_ff[4];

  logic cs_q_ff;
  logic sclk_q_ff;
  wire cs_rise = cs_n_s && !cs_q_ff;
  wire sclk_rise = sclk_s && !sclk_q_ff;
  wire sclk_fall = !sclk_s && sclk_q_ff;

  // Pause unit
  sfph_hold_if hif ();
  assign hif.cs_n = cs_n_s;
  assign hif.sclk_lo = !sclk_s;
  assign hif.hold_n = hold_n_s;
  wire paused = hif.paused;
  sfph_hold u_hold (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .h(hif.unit)
  );

  // One-time memory
  sfph_mem_if mif ();
  sfph_otp_mem u_otp (
    .sys_clk_i(sys_clk_i),
    .m(mif.mem)
  );

  // Shifter state
  sfph_state_t state_ff;
  logic [7:0] shreg_ff;
  logic [2:0] bit_idx_ff;
  logic [2:0] byte_cnt_ff;
  logic [7:0] cmd_ff;
  logic [23:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] so_sh_ff;
  logic rd_sec_ff;

  // Protection state
  logic write_latch_ff;
  logic [3:0] bp_ff;
  logic sr_lock_ff;
  logic dpd_ff;
  logic otp_mode_ff;
  logic fact_lock_ff;
  logic cust_lock_ff;
  logic strap_done_ff;

  // Output flops
  logic op_start_ff;
  sfph_opk_t op_kind_ff;
  logic reject_ff;
  logic so_ff;
  logic so_oe_ff;

  wire [7:0] nxt_byte = {shreg_ff[6:0], si_s};
  wire shift_en = (state_ff == ST_SHIFT) && !paused && sclk_rise;
  wire byte_done = shift_en && (bit_idx_ff == 3'h7);

  // Block protection decode
  wire [6:0] blk = addr_ff[`SFPH_BLK_MSB_C:`SFPH_BLK_LSB_C];
  wire [7:0] top_span = 8'h02 << (bp_ff[2:0] - 3'h1);
  wire [7:0] bot_span = 8'h02 << (3'h6 - bp_ff[2:0]);
  wire lvl_all = (bp_ff == 4'h7) || (bp_ff == 4'h8) || (bp_ff == 4'hf);
  wire top_hit = !bp_ff[3] && (bp_ff != 4'h0) && ({1'b0, blk} >= (`SFPH_BLK_COUNT_C - top_span));
  wire bot_hit = bp_ff[3] && ({1'b0, blk} < (`SFPH_BLK_COUNT_C - bot_span));
  wire tgt_prot = lvl_all || top_hit || bot_hit;

  // Command decode
  wire c_write_enable_cmd = cmd_ff == `SFPH_OP_WRITE_ENABLE_CMD_C;
  wire c_write_disable_cmd = cmd_ff == `SFPH_OP_WRITE_DISABLE_CMD_C;
  wire c_status_write_cmd = cmd_ff == `SFPH_OP_STATUS_WRITE_CMD_C;
  wire c_pp = cmd_ff == `SFPH_OP_PP_C;
  wire c_se = cmd_ff == `SFPH_OP_SE_C;
  wire c_be = (cmd_ff == `SFPH_OP_BE_A_C) || (cmd_ff == `SFPH_OP_BE_B_C);
  wire c_ce = (cmd_ff == `SFPH_OP_CE_A_C) || (cmd_ff == `SFPH_OP_CE_B_C);
  wire c_dp = cmd_ff == `SFPH_OP_DP_C;
  wire c_wake = cmd_ff == `SFPH_OP_WAKE_C;
  wire c_otp_enter_cmd = cmd_ff == `SFPH_OP_OTP_ENTER_CMD_C;
  wire c_otp_exit_cmd = cmd_ff == `SFPH_OP_OTP_EXIT_CMD_C;
  wire c_lock_write_cmd = cmd_ff == `SFPH_OP_LOCK_WRITE_CMD_C;
  wire c_short = c_write_enable_cmd || c_write_disable_cmd || c_ce || c_dp || c_otp_enter_cmd || c_otp_exit_cmd || c_lock_write_cmd;
  wire c_known = c_short || c_status_write_cmd || c_pp || c_se || c_be || c_wake;

  wire on_byte = (bit_idx_ff == 3'h0) && (byte_cnt_ff != 3'h0);
  wire len_ok = on_byte && ((c_short && byte_cnt_ff == `SFPH_LEN_SHORT_C)
    || (c_status_write_cmd && byte_cnt_ff == `SFPH_LEN_STATUS_WRITE_CMD_C)
    || ((c_se || c_be) && byte_cnt_ff == `SFPH_LEN_ERASE_C)
    || (c_pp && byte_cnt_ff >= `SFPH_LEN_PP_MIN_C) || c_wake);

  // Frame ends: deselect during pause only resets the interface
  wire frame_end = cs_rise && (state_ff == ST_SHIFT) && !paused;
  wire exec = frame_end && c_known && len_ok && (!dpd_ff || c_wake);
  wire hard_prot = sr_lock_ff && !wp_n_s;
  wire modify = c_status_write_cmd || c_pp || c_se || c_be || c_ce;
  wire otp_byte_locked = (addr_ff[5:0] <= `SFPH_OTP_ESN_END_C) ? fact_lock_ff : cust_lock_ff;
  wire mod_ok = write_latch_ff && !busy_i;
  wire do_status_write_cmd = exec && c_status_write_cmd && mod_ok && !hard_prot;
  wire do_arr = exec && (c_pp || c_se || c_be) && !otp_mode_ff && mod_ok && !tgt_prot;
  wire do_ce = exec && c_ce && !otp_mode_ff && mod_ok && (bp_ff == 4'h0);
  wire do_otp_pp = exec && c_pp && otp_mode_ff && mod_ok && !otp_byte_locked;
  wire do_lock = exec && c_lock_write_cmd && write_latch_ff;
  wire refused = frame_end && !(do_status_write_cmd || do_arr || do_ce || do_otp_pp || (exec && !modify));
  wire latch_clr = do_status_write_cmd || do_arr || do_ce || do_otp_pp || (exec && c_write_disable_cmd);

  wire sec_rd_start = byte_done && (byte_cnt_ff == 3'h0) && (nxt_byte == `SFPH_OP_RDSCUR_C) && !dpd_ff;
  wire [7:0] sec_val = {6'h00, cust_lock_ff, fact_lock_ff};
  wire [7:0] sr_byte = addr_ff[23:16];

  assign mif.we = do_otp_pp;
  assign mif.waddr = addr_ff[`SFPH_OTP_AW_C-1:0];
  assign mif.wdata = data_ff;
  assign mif.raddr = otp_rd_addr_i;

  // Serial front end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ST_STANDBY;
      cs_q_ff <= 1'b1;
      sclk_q_ff <= 1'b0;
      shreg_ff <= 8'h00;
      bit_idx_ff <= 3'h0;
      byte_cnt_ff <= 3'h0;
    end else begin
      cs_q_ff <= cs_n_s;
      sclk_q_ff <= sclk_s;
      if (cs_n_s) begin
        state_ff <= ST_STANDBY;
        bit_idx_ff <= 3'h0;
        byte_cnt_ff <= 3'h0;
      end else if (state_ff == ST_STANDBY && cs_q_ff) begin
        state_ff <= ST_SHIFT;
      end else if (shift_en) begin
        shreg_ff <= nxt_byte;
        bit_idx_ff <= bit_idx_ff + 3'h1;
        if (byte_done && byte_cnt_ff != 3'h7) begin
          byte_cnt_ff <= byte_cnt_ff + 3'h1;
        end
      end
    end
  end

  // Command, address and first data byte capture
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_ff <= 8'h00;
      addr_ff <= 24'h000000;
      data_ff <= 8'h00;
    end else if (byte_done) begin
      case (byte_cnt_ff)
        3'h0: cmd_ff <= nxt_byte;
        3'h1: addr_ff[23:16] <= nxt_byte;
        3'h2: addr_ff[15:8] <= nxt_byte;
        3'h3: addr_ff[7:0] <= nxt_byte;
        3'h4: data_ff <= nxt_byte;
        default: data_ff <= data_ff;
      endcase
    end
  end

  // Security register read-out, shifted on falling clock
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_sec_ff <= 1'b0;
      so_sh_ff <= 8'h00;
      so_ff <= 1'b0;
      so_oe_ff <= 1'b0;
    end else begin
      so_oe_ff <= rd_sec_ff && !cs_n_s && !paused;
      if (cs_n_s) begin
        rd_sec_ff <= 1'b0;
      end else if (sec_rd_start) begin
        rd_sec_ff <= 1'b1;
        so_sh_ff <= sec_val;
      end else if (rd_sec_ff && sclk_fall && !paused) begin
        so_ff <= so_sh_ff[7];
        so_sh_ff <= {so_sh_ff[6:0], so_sh_ff[7]};
      end
    end
  end

  // Latch, protection field and modes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_latch_ff <= 1'b0;
      bp_ff <= `SFPH_BP_RST_C;
      sr_lock_ff <= 1'b0;
      dpd_ff <= 1'b0;
      otp_mode_ff <= 1'b0;
    end else if (exec) begin
      if (c_write_enable_cmd) begin
        write_latch_ff <= 1'b1;
      end else if (latch_clr) begin
        write_latch_ff <= 1'b0;
      end
      if (do_status_write_cmd) begin
        bp_ff <= sr_byte[`SFPH_SR_BP_LSB_C+3:`SFPH_SR_BP_LSB_C];
        sr_lock_ff <= sr_byte[`SFPH_SR_LOCK_BIT_C];
      end
      if (c_dp) begin
        dpd_ff <= 1'b1;
      end else if (c_wake) begin
        dpd_ff <= 1'b0;
      end
      if (c_otp_enter_cmd) begin
        otp_mode_ff <= 1'b1;
      end else if (c_otp_exit_cmd) begin
        otp_mode_ff <= 1'b0;
      end
    end
  end

  // The status byte of a status write is the second frame byte
  // One-time locks: factory strap caught once after reset, both sticky
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      strap_done_ff <= 1'b0;
      fact_lock_ff <= 1'b0;
      cust_lock_ff <= 1'b0;
    end else begin
      strap_done_ff <= 1'b1;
      if (!strap_done_ff) begin
        fact_lock_ff <= factory_lock_i;
      end
      if (do_lock) begin
        cust_lock_ff <= 1'b1;
      end
    end
  end

  // Core operation launch
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      op_start_ff <= 1'b0;
      op_kind_ff <= OPK_NONE;
      reject_ff <= 1'b0;
    end else begin
      op_start_ff <= do_status_write_cmd || do_arr || do_ce;
      reject_ff <= refused;
      if (do_status_write_cmd) begin
        op_kind_ff <= OPK_STATUS_WRITE_CMD;
      end else if (do_arr) begin
        op_kind_ff <= c_pp ? OPK_PP : (c_se ? OPK_SE : OPK_BE);
      end else if (do_ce) begin
        op_kind_ff <= OPK_CE;
      end
    end
  end

  assign so_o = so_ff;
  assign so_oe_o = so_oe_ff;
  assign op_start_o = op_start_ff;
  assign op_kind_o = op_kind_ff;
  assign op_addr_o = addr_ff;
  assign op_data_o = data_ff;
  assign cmd_reject_o = reject_ff;
  assign write_latch_o = write_latch_ff;
  assign protect_level_o = bp_ff;
  assign status_write_lock_o = sr_lock_ff;
  assign deep_pd_o = dpd_ff;
  assign otp_mode_o = otp_mode_ff;
  assign sec_reg_o = {6'h00, cust_lock_ff, fact_lock_ff};
  assign paused_o = paused;
  assign otp_rd_data_o = mif.rdata;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_write_enable_cmd_sets_latch: assert property (exec && c_write_enable_cmd |=> write_latch_ff)
    else $error("write enable did not set latch");
  a_op_needs_latch: assert property ($rose(op_start_ff) |-> $past(write_latch_ff))
    else $error("operation started with latch clear");
  a_latch_cleared: assert property (op_start_ff |-> !write_latch_ff)
    else $error("latch still set after operation");
  a_boundary_check: assert property (frame_end && bit_idx_ff != 3'h0 |=> !op_start_ff && reject_ff)
    else $error("partial byte command accepted");
  a_dpd_ignores: assert property (dpd_ff && frame_end && !c_wake |=> dpd_ff && !op_start_ff)
    else $error("command run in deep power-down");
  a_prot_block: assert property (do_arr |-> !tgt_prot && !(bp_ff == 4'h8))
    else $error("protected block operated on");
  a_prot_refuse_keep: assert property (exec && c_se && tgt_prot && !otp_mode_ff
    |=> !op_start_ff && write_latch_ff == $past(write_latch_ff))
    else $error("refused erase touched latch");
  a_otp_no_array: assert property ($rose(op_start_ff) && op_kind_ff != OPK_STATUS_WRITE_CMD |-> !$past(otp_mode_ff))
    else $error("array accessed in one-time mode");
  a_lock_sticky: assert property (cust_lock_ff && fact_lock_ff == $past(fact_lock_ff) |=> cust_lock_ff)
    else $error("customer lock cleared");
  a_otp_locked_write: assert property (mif.we |-> !otp_byte_locked)
    else $error("locked one-time byte written");
  a_hpm_freeze: assert property (hard_prot && !do_status_write_cmd |=> bp_ff == $past(bp_ff))
    else $error("protection field changed under hardware protect");
  a_pause_float: assert property (paused |=> !so_oe_ff)
    else $error("output driven while paused");

endmodule // sfph_top

// [test/sfph_spi_master.sv]
// SPI mode 0 master model driving the serial pins of the flash block.
// Assumes a 20 ns system clock; each serial clock phase lasts 4 system clocks.
`timescale 1ns/1ns

module sfph_spi_master (
  // Clock
  input wire logic sys_clk_i,
  // Serial pins
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  output logic hold_n_o,
  input wire logic so_i
);
  logic [7:0] rx_byte;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
    hold_n_o = 1'b1;
    rx_byte = 8'h00;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask

  task automatic clk_lvl(input logic v);
    sclk_o = v;
    wait_clk(4);
  endtask

  // Data changes while the clock is low and is taken at the rising edge
  task automatic tx1(input logic b);
    si_o = b;
    wait_clk(4);
    sclk_o = 1'b1;
    rx_byte = {rx_byte[6:0], so_i};
    wait_clk(4);
    sclk_o = 1'b0;
  endtask

  task automatic tx8(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      tx1(b[i]);
    end
  endtask

  task automatic sel();
    cs_n_o = 1'b0;
    wait_clk(4);
  endtask

  // A released data line shows the inverse of its last value
  task automatic desel();
    wait_clk(4);
    cs_n_o = 1'b1;
    si_o = ~si_o;
    wait_clk(8);
  endtask

  task automatic set_hold(input logic v);
    hold_n_o = v;
    wait_clk(6);
  endtask
endmodule // sfph_spi_master

// [test/sfph_top_tb.sv]
// Self-checking bench of the flash protection and pause block.
// Assumes the block's headers in the include path and the master model.
`timescale 1ns/1ns
`include "sfph_consts.svh"

module sfph_top_tb
  import sfph_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic busy;
  logic wp_n;
  logic fact;
  logic [5:0] rd_addr;
  logic cs_n, sclk, si, hold_n, so, so_oe, op_start, cmd_reject, latch, lock, dpd, otpm, paused;
  sfph_opk_t op_kind;
  logic [23:0] op_addr;
  logic [7:0] op_data, sec, rd_data;
  logic [3:0] level;
  int n_fail = 0;
  int n_checks = 0;
  int n_start = 0, n_rej = 0, s0 = 0, r0 = 0, cyc = 0;

  always #10 sys_clk = ~sys_clk;

  sfph_spi_master u_master (.sys_clk_i(sys_clk), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si),
    .hold_n_o(hold_n), .so_i(so_oe ? so : !so));

  sfph_top u_dut (.sys_clk_i(sys_clk), .rst_i(rst), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
    .hold_n_i(hold_n), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .factory_lock_i(fact),
    .busy_i(busy), .op_start_o(op_start), .op_kind_o(op_kind), .op_addr_o(op_addr),
    .op_data_o(op_data), .cmd_reject_o(cmd_reject), .write_latch_o(latch),
    .protect_level_o(level), .status_write_lock_o(lock), .deep_pd_o(dpd), .otp_mode_o(otpm),
    .sec_reg_o(sec), .paused_o(paused), .otp_rd_addr_i(rd_addr), .otp_rd_data_o(rd_data));

  task automatic end_sim();
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (op_start === 1'b1) n_start = n_start + 1;
    if (cmd_reject === 1'b1) n_rej = n_rej + 1;
    if (cyc == 90000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Launches and refusals counted since the previous call
  task automatic ops(input int s, input int r);
    check(n_start - s0, s);
    check(n_rej - r0, r);
    s0 = n_start;
    r0 = n_rej;
  endtask

  task automatic do_reset(input logic f);
    fact = f;
    rst = 1'b1;
    u_master.wait_clk(4);
    rst = 1'b0;
    u_master.wait_clk(3);
    s0 = n_start;
    r0 = n_rej;
  endtask

  task automatic cmd1(input logic [7:0] op);
    u_master.sel();
    u_master.tx8(op);
    u_master.desel();
  endtask

  task automatic cmd2(input logic [7:0] op, input logic [7:0] d);
    u_master.sel();
    u_master.tx8(op);
    u_master.tx8(d);
    u_master.desel();
  endtask

  task automatic hdr(input logic [7:0] op, input logic [23:0] a);
    u_master.sel();
    u_master.tx8(op);
    u_master.tx8(a[23:16]);
    u_master.tx8(a[15:8]);
    u_master.tx8(a[7:0]);
  endtask

  task automatic cmd4(input logic [7:0] op, input logic [23:0] a);
    hdr(op, a);
    u_master.desel();
  endtask

  task automatic cmd5(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d);
    hdr(op, a);
    u_master.tx8(d);
    u_master.desel();
  endtask

  function automatic logic prot(input int lv, input int b);
    int k;
    k = (lv < 7) ? lv : 15 - lv;
    if (lv == 0) return 1'b0;
    if (lv == 7 || lv == 8 || lv == 15) return 1'b1;
    if (lv < 7) return b >= 128 - (1 << k);
    return b < 128 - (1 << k);
  endfunction

  task automatic probe(input int lv, input int b, input logic [7:0] op);
    logic pr;
    pr = prot(lv, b & 127);
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    cmd4(op, {1'b0, b[6:0], 16'h8000});
    ops(pr ? 0 : 1, pr ? 1 : 0);
    check(latch, pr);
  endtask

  task automatic otp_wr(input logic [5:0] a, input logic [7:0] d);
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    cmd5(`SFPH_OP_PP_C, {18'h00000, a}, d);
  endtask

  task automatic otp_rd(input logic [5:0] a, input logic [7:0] d);
    rd_addr = a;
    u_master.wait_clk(2);
    check(rd_data, d);
  endtask

  initial begin
    logic [7:0] sb;
    int k, bnd;
    busy = 1'b0;
    wp_n = 1'b1;
    rd_addr = 6'h00;
    do_reset(1'b0);
    check({level, dpd, otpm, paused, latch, so_oe}, 9'h000);
    cmd4(`SFPH_OP_SE_C, 24'h012345);
    ops(0, 1);
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    check(latch, 1'b1);
    cmd4(`SFPH_OP_SE_C, 24'h012345);
    ops(1, 0);
    check({op_kind, op_addr, latch}, {OPK_SE, 24'h012345, 1'b0});
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    cmd1(`SFPH_OP_WRITE_DISABLE_CMD_C);
    check(latch, 1'b0);
    // Command cut two bits past a byte boundary
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    u_master.sel();
    u_master.tx8(`SFPH_OP_SE_C);
    u_master.tx8(8'h01);
    u_master.tx1(1'b0);
    u_master.tx1(1'b1);
    u_master.desel();
    ops(0, 1);
    check(latch, 1'b1);
    cmd1(`SFPH_OP_CE_A_C);
    ops(1, 0);
    check({op_kind, latch}, {OPK_CE, 1'b0});
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    busy = 1'b1;
    cmd1(`SFPH_OP_CE_B_C);
    busy = 1'b0;
    ops(0, 1);
    cmd1(`SFPH_OP_DP_C);
    check(dpd, 1'b1);
    cmd1(`SFPH_OP_WRITE_DISABLE_CMD_C);
    ops(0, 1);
    check(latch, 1'b1);
    cmd1(`SFPH_OP_WAKE_C);
    check(dpd, 1'b0);
    // Clock pulses while paused must not shift in
    cmd1(`SFPH_OP_WRITE_DISABLE_CMD_C);
    u_master.sel();
    u_master.tx8(`SFPH_OP_WRITE_ENABLE_CMD_C);
    u_master.set_hold(1'b0);
    check({paused, so_oe}, 2'b10);
    u_master.tx8(8'hff);
    u_master.set_hold(1'b1);
    check(paused, 1'b0);
    u_master.desel();
    ops(0, 0);
    check(latch, 1'b1);
    u_master.sel();
    u_master.tx8(`SFPH_OP_WRITE_ENABLE_CMD_C);
    u_master.desel();
    check(latch, 1'b1);
    // Entry and exit held back while the serial clock is high
    u_master.sel();
    u_master.clk_lvl(1'b1);
    u_master.set_hold(1'b0);
    check(paused, 1'b0);
    u_master.clk_lvl(1'b0);
    u_master.wait_clk(2);
    check(paused, 1'b1);
    u_master.clk_lvl(1'b1);
    u_master.set_hold(1'b1);
    check(paused, 1'b1);
    u_master.clk_lvl(1'b0);
    u_master.wait_clk(2);
    check(paused, 1'b0);
    u_master.set_hold(1'b0);
    u_master.desel();
    check(paused, 1'b0);
    u_master.set_hold(1'b1);
    ops(0, 0);
    for (int lv = 0; lv < 16; lv++) begin
      do_reset(1'b0);
      sb = {2'b00, lv[3:0], 2'b00};
      cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
      cmd5(`SFPH_OP_PP_C, 24'h000000, 8'h00);
      cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
      cmd2(`SFPH_OP_STATUS_WRITE_CMD_C, sb);
      ops(2, 0);
      check(level, lv);
      k = (lv < 7) ? lv : 15 - lv;
      bnd = 128 - (1 << k);
      probe(lv, 0, `SFPH_OP_SE_C);
      probe(lv, 127, `SFPH_OP_BE_B_C);
      probe(lv, bnd - 1, `SFPH_OP_BE_A_C);
      probe(lv, bnd, `SFPH_OP_BE_B_C);
    end
    do_reset(1'b0);
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    cmd5(`SFPH_OP_PP_C, 24'h000000, 8'h5a);
    check({op_kind, op_data}, {OPK_PP, 8'h5a});
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    cmd2(`SFPH_OP_STATUS_WRITE_CMD_C, 8'hbc);
    check({lock, level}, 5'h1f);
    wp_n = 1'b0;
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    cmd2(`SFPH_OP_STATUS_WRITE_CMD_C, 8'h00);
    cmd1(`SFPH_OP_CE_B_C);
    ops(2, 2);
    check({lock, level, latch}, 6'h3f);
    wp_n = 1'b1;
    do_reset(1'b0);
    cmd1(`SFPH_OP_OTP_ENTER_CMD_C);
    check(otpm, 1'b1);
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    cmd4(`SFPH_OP_BE_B_C, 24'h000000);
    ops(0, 1);
    otp_wr(6'h03, 8'h3c);
    otp_wr(6'h10, 8'h96);
    ops(0, 0);
    check(latch, 1'b0);
    otp_rd(6'h03, 8'h3c);
    otp_rd(6'h10, 8'h96);
    do_reset(1'b1);
    check(sec, 8'h01);
    cmd1(`SFPH_OP_OTP_ENTER_CMD_C);
    otp_wr(6'h03, 8'h55);
    otp_rd(6'h03, 8'h3c);
    cmd1(`SFPH_OP_WRITE_ENABLE_CMD_C);
    cmd1(`SFPH_OP_LOCK_WRITE_CMD_C);
    check(sec, 8'h03);
    otp_wr(6'h10, 8'h69);
    otp_rd(6'h10, 8'h96);
    cmd1(`SFPH_OP_OTP_EXIT_CMD_C);
    check(otpm, 1'b0);
    u_master.sel();
    u_master.tx8(`SFPH_OP_RDSCUR_C);
    u_master.tx8(8'h00);
    check(so_oe, 1'b1);
    u_master.desel();
    check(u_master.rx_byte, 8'h03);
    check(so_oe, 1'b0);
    end_sim();
  end
endmodule // sfph_top_tb
